// ===== hzc_map.svh
// Register offsets, field positions and reset values of the output shutdown control
`ifndef HZC_MAP_SVH
`define HZC_MAP_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define HZC_ADDR_W 5
`define HZC_OFS_SEL 5'h00
`define HZC_OFS_CTL 5'h04
`define HZC_OFS_IRQ_STAT 5'h08
`define HZC_OFS_IRQ_EN 5'h0c
`define HZC_OFS_IRQ_CLR 5'h10

// ************************************************************
// Selection register fields
// ************************************************************
`define HZC_SEL_PIN_LO 0
`define HZC_SEL_TRIG_EN 4
`define HZC_SEL_SRC_LO 6
`define HZC_SEL_RST 8'h00

// ************************************************************
// Control register fields
// ************************************************************
`define HZC_CTL_FLAG 0
`define HZC_CTL_CLEAR 2
`define HZC_CTL_FORCE 3
`define HZC_CTL_EDGE_LO 4
`define HZC_CTL_MODE 6
`define HZC_CTL_EN 7
`define HZC_CTL_RST 4'h0

// ************************************************************
// Interrupt bits and bus responses
// ************************************************************
`define HZC_IRQ_ENTER 0
`define HZC_IRQ_LEAVE 1
`define HZC_IRQ_RST 2'h0
`define HZC_RESP_OKAY 2'h0
`define HZC_RESP_SLVERR 2'h2

`endif

// ===== hzc_pkg.sv
// Types shared by the output shutdown control
package hzc_pkg;
  // Trigger source choice
  typedef enum logic [1:0] {HZC_SRC_EXT, HZC_SRC_CMP0, HZC_SRC_CMP1, HZC_SRC_CMP2} hzc_src_type;
  // Valid edge choice
  typedef enum logic [1:0] {HZC_EDGE_NONE, HZC_EDGE_RISE, HZC_EDGE_FALL, HZC_EDGE_BAD} hzc_edge_type;
  // One tri-state request per target pin
  typedef logic [3:0] hzc_pins_type;
endpackage : hzc_pkg

// ===== hzc_ctl.sv
// Output shutdown control: trigger select, edge detect, state flag and AXI4-Lite registers
`include "hzc_map.svh"

// Function
// - Mode one: clear works only once trigger inactive
// - Mode zero: clear always releases the pins
// - Clear beats coincident edge in mode zero
// - Force sets flag; unconditional without edge
// - Source select: external input or comparators
// - Edge field: none, rising, falling, prohibited
// - Flag set by force/edge, held until clear or disable
// - Only edges after enabling trigger shutdown
module hzc_ctl (
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic [`HZC_ADDR_W-1:0] I_S_AXI_AWADDR,
  input wire logic I_S_AXI_AWVALID,
  output logic O_S_AXI_AWREADY,
  input wire logic [31:0] I_S_AXI_WDATA,
  input wire logic [3:0] I_S_AXI_WSTRB,
  input wire logic I_S_AXI_WVALID,
  output logic O_S_AXI_WREADY,
  output logic [1:0] O_S_AXI_BRESP,
  output logic O_S_AXI_BVALID,
  input wire logic I_S_AXI_BREADY,
  input wire logic [`HZC_ADDR_W-1:0] I_S_AXI_ARADDR,
  input wire logic I_S_AXI_ARVALID,
  output logic O_S_AXI_ARREADY,
  output logic [31:0] O_S_AXI_RDATA,
  output logic [1:0] O_S_AXI_RRESP,
  output logic O_S_AXI_RVALID,
  input wire logic I_S_AXI_RREADY,
  input wire logic I_EXT_IRQ_INPUT,
  input wire logic [2:0] I_CMP_OUT,
  output hzc_pkg::hzc_pins_type O_PIN_HIZ,
  output logic O_SHUTDOWN_STATE_FLAG,
  output logic O_IRQ
);
  import hzc_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************
  logic aw_full_reg; // Write address held
  logic [`HZC_ADDR_W-1:0] aw_addr_reg; // Held write address
  logic w_full_reg; // Write data held
  logic [31:0] w_data_reg; // Held write data
  logic [3:0] w_strb_reg; // Held byte strobes
  logic bvalid_reg; // Write answer pending
  logic [1:0] bresp_reg; // Write answer code
  logic rvalid_reg; // Read answer pending
  logic [31:0] rdata_reg; // Read answer data
  logic [1:0] rresp_reg; // Read answer code
  logic do_write; // Both halves present this cycle
  logic wr_lane0; // Low byte written
  logic hit_sel, hit_ctl, hit_clr, hit_en; // Write decode
  hzc_src_type src_reg; // Trigger source
  hzc_pins_type pin_sel_reg; // Target pins
  logic trig_en_reg; // Trigger input enable
  logic ctl_en_reg, mode_reg; // Shutdown control enable and release condition mode
  hzc_edge_type edge_reg; // Valid edge choice
  logic flag_reg; // Shutdown state flag
  logic [1:0] irq_stat_reg, irq_en_reg; // Sticky events and their enables
  logic [3:0] trig_all; // Trigger candidates, external input in bit 0
  logic trig_sig; // Selected, gated trigger
  logic trig_prev_reg; // Trigger one cycle ago
  logic trig_active, edge_hit; // Trigger at its abnormal level; valid edge this cycle
  logic force_wr, clear_wr; // Force and clear bits written
  logic force_ok, clear_ok; // Force and clear accepted
  logic flag_next; // Next flag value
  logic [1:0] irq_event, irq_clr; // Events and clear strobes this cycle

  // ************************************************************
  // AXI4-Lite write channels
  // ************************************************************
  // Each half is taken when its slot is free and no answer waits
  assign O_S_AXI_AWREADY = !aw_full_reg && !bvalid_reg;
  assign O_S_AXI_WREADY = !w_full_reg && !bvalid_reg;
  assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_lane0 = do_write && w_strb_reg[0];
  assign hit_sel = wr_lane0 && (aw_addr_reg == `HZC_OFS_SEL);
  assign hit_ctl = wr_lane0 && (aw_addr_reg == `HZC_OFS_CTL);
  assign hit_en = wr_lane0 && (aw_addr_reg == `HZC_OFS_IRQ_EN);
  assign hit_clr = wr_lane0 && (aw_addr_reg == `HZC_OFS_IRQ_CLR);

  // Address slot
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (I_S_AXI_AWVALID && O_S_AXI_AWREADY) begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= {I_S_AXI_AWADDR[`HZC_ADDR_W-1:2], 2'b00};
    end else if (do_write) begin
      aw_full_reg <= 1'b0;
    end
  end

  // Data slot
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      w_full_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (I_S_AXI_WVALID && O_S_AXI_WREADY) begin
      w_full_reg <= 1'b1;
      w_data_reg <= I_S_AXI_WDATA;
      w_strb_reg <= I_S_AXI_WSTRB;
    end else if (do_write) begin
      w_full_reg <= 1'b0;
    end
  end

  // Write answer, error on unmapped offsets
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `HZC_RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (aw_addr_reg > `HZC_OFS_IRQ_CLR) ? `HZC_RESP_SLVERR : `HZC_RESP_OKAY;
    end else if (I_S_AXI_BREADY) begin
      bvalid_reg <= 1'b0;
    end
  end
  assign O_S_AXI_BVALID = bvalid_reg;
  assign O_S_AXI_BRESP = bresp_reg;

  // ************************************************************
  // AXI4-Lite read channel
  // ************************************************************
  assign O_S_AXI_ARREADY = !rvalid_reg;

  // Read mux; strobe bits read zero, unmapped reads zero with error
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= `HZC_RESP_OKAY;
    end else if (I_S_AXI_ARVALID && O_S_AXI_ARREADY) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= `HZC_RESP_OKAY;
      rdata_reg <= '0;
      unique case ({I_S_AXI_ARADDR[`HZC_ADDR_W-1:2], 2'b00})
        `HZC_OFS_SEL: begin
          rdata_reg[`HZC_SEL_SRC_LO +: 2] <= src_reg;
          rdata_reg[`HZC_SEL_TRIG_EN] <= trig_en_reg;
          rdata_reg[`HZC_SEL_PIN_LO +: 4] <= pin_sel_reg;
        end
        `HZC_OFS_CTL: begin
          rdata_reg[`HZC_CTL_EN] <= ctl_en_reg;
          rdata_reg[`HZC_CTL_MODE] <= mode_reg;
          rdata_reg[`HZC_CTL_EDGE_LO +: 2] <= edge_reg;
          rdata_reg[`HZC_CTL_FLAG] <= flag_reg;
        end
        `HZC_OFS_IRQ_STAT: rdata_reg[1:0] <= irq_stat_reg;
        `HZC_OFS_IRQ_EN: rdata_reg[1:0] <= irq_en_reg;
        `HZC_OFS_IRQ_CLR: rdata_reg <= '0; // Clear register is write-only
        default: rresp_reg <= `HZC_RESP_SLVERR; // Unmapped offset
      endcase
    end else if (I_S_AXI_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign O_S_AXI_RVALID = rvalid_reg;
  assign O_S_AXI_RDATA = rdata_reg;
  assign O_S_AXI_RRESP = rresp_reg;

  // ************************************************************
  // Configuration registers
  // ************************************************************
  // Source, pins and trigger enable; software orders these writes
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      src_reg <= HZC_SRC_EXT;
      pin_sel_reg <= '0;
      trig_en_reg <= 1'b0;
    end else if (hit_sel) begin
      src_reg <= hzc_src_type'(w_data_reg[`HZC_SEL_SRC_LO +: 2]);
      pin_sel_reg <= w_data_reg[`HZC_SEL_PIN_LO +: 4];
      trig_en_reg <= w_data_reg[`HZC_SEL_TRIG_EN];
    end
  end

  // Control fields; force and clear are strobes, never stored
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      {ctl_en_reg, mode_reg} <= 2'(`HZC_CTL_RST >> 2);
      edge_reg <= hzc_edge_type'(2'(`HZC_CTL_RST));
    end else if (hit_ctl) begin
      ctl_en_reg <= w_data_reg[`HZC_CTL_EN];
      mode_reg <= w_data_reg[`HZC_CTL_MODE];
      edge_reg <= hzc_edge_type'(w_data_reg[`HZC_CTL_EDGE_LO +: 2]);
    end
  end
  assign force_wr = hit_ctl && w_data_reg[`HZC_CTL_FORCE];
  assign clear_wr = hit_ctl && w_data_reg[`HZC_CTL_CLEAR];

  // ************************************************************
  // Trigger selection and edge detection
  // ************************************************************
  // Source mux gated by the trigger input enable; source code N picks bit N
  assign trig_all = {I_CMP_OUT, I_EXT_IRQ_INPUT};
  assign trig_sig = trig_all[src_reg] && trig_en_reg;

  // Previous sample; a level already active gives no edge
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      trig_prev_reg <= 1'b0;
    end else begin
      trig_prev_reg <= trig_sig;
    end
  end

  // Active level and valid edge; the prohibited code never triggers
  always_comb begin
    trig_active = 1'b0;
    edge_hit = 1'b0;
    unique case (edge_reg)
      HZC_EDGE_RISE: begin
        trig_active = trig_sig;
        edge_hit = trig_sig && !trig_prev_reg;
      end
      HZC_EDGE_FALL: begin
        trig_active = !trig_sig;
        edge_hit = !trig_sig && trig_prev_reg;
      end
      HZC_EDGE_NONE, HZC_EDGE_BAD: edge_hit = 1'b0; // No edge chosen, or the prohibited code
    endcase
    edge_hit = edge_hit && ctl_en_reg;
  end

  // ************************************************************
  // Shutdown state flag
  // ************************************************************
  // Force needs an inactive trigger unless no edge is chosen
  assign force_ok = force_wr && ctl_en_reg && !trig_active;
  // Mode zero ignores the trigger mode one needs it idle
  assign clear_ok = clear_wr && ctl_en_reg && (!mode_reg || (!trig_active && !edge_hit));

  // Clear outranks set, so a coincident edge loses in mode zero
  assign flag_next = (!ctl_en_reg || clear_ok) ? 1'b0 : (force_ok || edge_hit || flag_reg);

  // Flag register
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end
  assign O_SHUTDOWN_STATE_FLAG = flag_reg;
  // Tri-state only the chosen pins
  assign O_PIN_HIZ = flag_reg ? pin_sel_reg : '0;

  // ************************************************************
  // Interrupts
  // ************************************************************
  assign irq_event = {flag_reg && !flag_next, !flag_reg && flag_next};
  assign irq_clr = hit_clr ? w_data_reg[1:0] : 2'b00;

  // Sticky status; a new event wins over its clear
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      irq_stat_reg <= `HZC_IRQ_RST;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_event;
    end
  end

  // Enable register
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      irq_en_reg <= `HZC_IRQ_RST;
    end else if (hit_en) begin
      irq_en_reg <= w_data_reg[1:0];
    end
  end
  assign O_IRQ = |(irq_stat_reg & irq_en_reg);

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_clear_mode0;
    @(posedge I_CLK) disable iff (I_SRST)
    clear_wr && ctl_en_reg && !mode_reg |=> !O_SHUTDOWN_STATE_FLAG;
  endproperty
  a_clear_mode0: assert property (p_clear_mode0) else $error("clear in mode 0 did not release");
  property p_clear_mode0_beats_edge;
    @(posedge I_CLK) disable iff (I_SRST)
    clear_wr && edge_hit && !mode_reg |=> O_PIN_HIZ == 4'h0;
  endproperty
  a_clear_mode0_beats_edge: assert property (p_clear_mode0_beats_edge) else $error("edge beat clear");
  property p_clear_mode1_blocked;
    @(posedge I_CLK) disable iff (I_SRST)
    clear_wr && mode_reg && trig_active && ctl_en_reg && flag_reg |=> flag_reg;
  endproperty
  a_clear_mode1_blocked: assert property (p_clear_mode1_blocked) else $error("clear worked while active");
  property p_edge_sets;
    @(posedge I_CLK) disable iff (I_SRST)
    edge_hit && !clear_wr ##1 ctl_en_reg |-> O_SHUTDOWN_STATE_FLAG;
  endproperty
  a_edge_sets: assert property (p_edge_sets) else $error("valid edge did not set flag");
  property p_force_noedge;
    @(posedge I_CLK) disable iff (I_SRST)
    force_wr && ctl_en_reg && edge_reg == HZC_EDGE_NONE && !clear_wr |=> flag_reg;
  endproperty
  a_force_noedge: assert property (p_force_noedge) else $error("force without edge ignored");
  property p_level_no_trigger;
    @(posedge I_CLK) disable iff (I_SRST)
    ctl_en_reg && trig_active && $past(trig_active) && $past(edge_reg) == edge_reg && !force_wr && !flag_reg
      |=> !flag_reg;
  endproperty
  a_level_no_trigger: assert property (p_level_no_trigger) else $error("steady level caused shutdown");
  property p_bad_edge;
    @(posedge I_CLK) disable iff (I_SRST)
    edge_reg == HZC_EDGE_BAD && !force_wr && !flag_reg |=> !flag_reg;
  endproperty
  a_bad_edge: assert property (p_bad_edge) else $error("prohibited edge code triggered");
  property p_ext_source;
    @(posedge I_CLK) disable iff (I_SRST)
    src_reg == HZC_SRC_EXT && trig_en_reg && $past(trig_en_reg) && $rose(I_EXT_IRQ_INPUT)
      && edge_reg == HZC_EDGE_RISE && ctl_en_reg && !clear_wr |=> flag_reg;
  endproperty
  a_ext_source: assert property (p_ext_source) else $error("external input edge missed");
  property p_pins;
    @(posedge I_CLK) disable iff (I_SRST)
    ##1 O_PIN_HIZ == ($past(flag_next) ? pin_sel_reg : 4'h0);
  endproperty
  a_pins: assert property (p_pins) else $error("wrong pins tri-stated");

endmodule : hzc_ctl

// ===== tb_hzc_ctl.sv
// Self-checking testbench of the output shutdown control
`include "hzc_map.svh"

module tb_hzc_ctl;
  timeunit 1ns;
  timeprecision 1ps;
  import hzc_pkg::*;

  // ************************************************************
  // Signals and bookkeeping
  // ************************************************************
  logic clk = 1'b0; // Bench clock, 50 MHz
  logic srst = 1'b1; // Synchronous reset
  logic [4:0] awaddr = 5'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [4:0] araddr = 5'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [3:0] trg = 4'h0; // Trigger inputs: bit 0 external, bits 3:1 comparators
  logic awready, wready, bvalid, arready, rvalid, flag, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  hzc_pins_type pin_hiz;
  hzc_pins_type pins = 4'h0; // Target pins chosen for the current setup
  logic [7:0] ctl_v = 8'h00; // Readable upper nibble of the control register's low byte
  logic [33:0] exp_q[$]; // Expected bus answers in issue order
  int failures = 0;
  int checked = 0;

  always #10 clk = ~clk;

  hzc_ctl u_hzc_ctl (
    .I_CLK(clk), .I_SRST(srst),
    .I_S_AXI_AWADDR(awaddr), .I_S_AXI_AWVALID(awvalid), .O_S_AXI_AWREADY(awready),
    .I_S_AXI_WDATA(wdata), .I_S_AXI_WSTRB(wstrb), .I_S_AXI_WVALID(wvalid), .O_S_AXI_WREADY(wready),
    .O_S_AXI_BRESP(bresp), .O_S_AXI_BVALID(bvalid), .I_S_AXI_BREADY(bready),
    .I_S_AXI_ARADDR(araddr), .I_S_AXI_ARVALID(arvalid), .O_S_AXI_ARREADY(arready),
    .O_S_AXI_RDATA(rdata), .O_S_AXI_RRESP(rresp), .O_S_AXI_RVALID(rvalid), .I_S_AXI_RREADY(rready),
    .I_EXT_IRQ_INPUT(trg[0]), .I_CMP_OUT(trg[3:1]),
    .O_PIN_HIZ(pin_hiz), .O_SHUTDOWN_STATE_FLAG(flag), .O_IRQ(irq)
  );

  // ************************************************************
  // Comparison, verdict and bus tasks
  // ************************************************************
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    if (failures == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  // A wait that ran out counts as a mismatch and ends the run
  task automatic timeout();
    failures++;
    summarize();
  endtask : timeout

  // Monitor: each bus answer is matched against the oldest note
  always @(posedge clk) begin
    if (bvalid === 1'b1 && bready) begin
      check({32'h0, bresp}, exp_q.size() > 0 ? exp_q.pop_front() : 34'hx);
    end
    if (rvalid === 1'b1 && rready) begin
      check({rdata, rresp}, exp_q.size() > 0 ? exp_q.pop_front() : 34'hx);
    end
  end

  // Write one word; address and data offered together, each released once taken
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_go, w_go, done;
    done = 1'b0;
    exp_q.push_back({32'h0, r});
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge clk);
      aw_go = awvalid && awready;
      w_go = wvalid && wready;
      done = bvalid;
      @(posedge clk);
      if (aw_go) awvalid <= 1'b0;
      if (w_go) wvalid <= 1'b0;
      if (done) bready <= 1'b0;
    end
    if (!done) timeout();
  endtask : wr

  // Read one word and note the answer it should bring
  task automatic rd(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
    logic a_go, done;
    done = 1'b0;
    exp_q.push_back({d, r});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge clk);
      a_go = arvalid && arready;
      done = rvalid;
      @(posedge clk);
      if (a_go) arvalid <= 1'b0;
      if (done) rready <= 1'b0;
    end
    if (!done) timeout();
  endtask : rd

  // ************************************************************
  // Scenario helpers
  // ************************************************************
  task automatic wc(input logic [7:0] v);
    ctl_v = v & 8'hf0;
    wr(`HZC_OFS_CTL, {24'h0, v}, `HZC_RESP_OKAY);
  endtask : wc

  // Drive the trigger inputs and let the edge detector see them
  task automatic drive(input logic [3:0] v);
    @(posedge clk);
    trg <= v;
    repeat (3) @(posedge clk);
  endtask : drive

  // Flag through the bus, then the flag and pin outputs directly
  task automatic fl(input logic f);
    rd(`HZC_OFS_CTL, {24'h0, ctl_v[7:4], 3'h0, f}, `HZC_RESP_OKAY);
    @(negedge clk);
    check({33'h0, flag}, {33'h0, f});
    check({30'h0, pin_hiz}, {30'h0, f ? pins : 4'h0});
  endtask : fl

  task automatic ck_irq(input logic v);
    @(negedge clk);
    check({33'h0, irq}, {33'h0, v});
  endtask : ck_irq

  // Disable, reselect, then enable in the documented order
  task automatic setup(input logic [1:0] s, input logic [7:0] m);
    wc(8'h00);
    wr(`HZC_OFS_SEL, {24'h0, s, 2'b00, pins}, `HZC_RESP_OKAY);
    wc(m);
    wr(`HZC_OFS_SEL, {24'h0, s, 2'b01, pins}, `HZC_RESP_OKAY);
    wc(m | 8'h80);
  endtask : setup

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    void'($urandom(32'hb3a14586));
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    ck_irq(1'b0);
    check({31'h0, awready, wready, arready}, {31'h0, 3'b111});
    fl(1'b0);
    for (int i = 0; i < 5; i++) rd(5'(i * 4), 32'h0, `HZC_RESP_OKAY);
    rd(5'h18, 32'h0, `HZC_RESP_SLVERR);
    wr(5'h14, 32'hff, `HZC_RESP_SLVERR);
    // A write without the low byte lane leaves the register alone
    wstrb <= 4'he;
    wr(`HZC_OFS_SEL, 32'hff, `HZC_RESP_OKAY);
    wstrb <= 4'hf;
    rd(`HZC_OFS_SEL, 32'h0, `HZC_RESP_OKAY);
    // Each source alone triggers; other inputs are ignored
    for (int s = 0; s < 4; s++) begin
      pins = 4'($urandom_range(15, 1));
      setup(2'(s), 8'h10);
      drive(4'hf & ~(4'h1 << s));
      fl(1'b0);
      drive(4'h0);
      drive(4'h1 << s);
      fl(1'b1);
      wc(8'h94);
      fl(1'b0);
      drive(4'h0);
    end
    // Trigger already active when enabled does not shut down
    drive(4'h1);
    setup(2'd0, 8'h10);
    fl(1'b0);
    drive(4'h0);
    drive(4'h1);
    fl(1'b1);
    // Falling edge selection
    setup(2'd0, 8'h20);
    fl(1'b0);
    drive(4'h0);
    fl(1'b1);
    wc(8'ha4);
    fl(1'b0);
    // Release mode one waits for the trigger to go inactive
    setup(2'd0, 8'h50);
    drive(4'h1);
    fl(1'b1);
    wc(8'hd4);
    fl(1'b1);
    drive(4'h0);
    wc(8'hd4);
    fl(1'b0);
    // Clear written as a rising edge arrives: the clear wins
    setup(2'd0, 8'h10);
    fork
      wc(8'h94);
      begin
        repeat (2) @(posedge clk);
        trg <= 4'h1;
      end
    join
    fl(1'b0);
    drive(4'h0);
    // Force with an edge selected needs an inactive trigger
    setup(2'd0, 8'h10);
    drive(4'h1);
    wc(8'h94);
    wc(8'h98);
    fl(1'b0);
    drive(4'h0);
    wc(8'h98);
    fl(1'b1);
    wc(8'h10);
    fl(1'b0);
    // No edge: inputs ignored, force always works
    setup(2'd0, 8'h00);
    drive(4'h1);
    fl(1'b0);
    wc(8'h88);
    fl(1'b1);
    wc(8'h84);
    fl(1'b0);
    drive(4'h0);
    // Prohibited edge code gives no trigger
    setup(2'd0, 8'h30);
    drive(4'h1);
    fl(1'b0);
    drive(4'h0);
    // Interrupt: raise, clear, mask
    setup(2'd0, 8'h00);
    wr(`HZC_OFS_IRQ_CLR, 32'h3, `HZC_RESP_OKAY);
    wr(`HZC_OFS_IRQ_EN, 32'h1, `HZC_RESP_OKAY);
    wc(8'h88);
    ck_irq(1'b1);
    rd(`HZC_OFS_IRQ_STAT, 32'h1, `HZC_RESP_OKAY);
    wc(8'h84);
    rd(`HZC_OFS_IRQ_STAT, 32'h3, `HZC_RESP_OKAY);
    wr(`HZC_OFS_IRQ_CLR, 32'h1, `HZC_RESP_OKAY);
    rd(`HZC_OFS_IRQ_STAT, 32'h2, `HZC_RESP_OKAY);
    ck_irq(1'b0);
    wr(`HZC_OFS_IRQ_EN, 32'h0, `HZC_RESP_OKAY);
    wc(8'h88);
    rd(`HZC_OFS_IRQ_STAT, 32'h3, `HZC_RESP_OKAY);
    ck_irq(1'b0);
    rd(`HZC_OFS_IRQ_CLR, 32'h0, `HZC_RESP_OKAY);
    repeat (2) @(posedge clk);
    summarize();
  end
endmodule : tb_hzc_ctl
